// file: common/smr_pkg.sv
// Package with mode register map, field layouts and codes for the mode register bank
package smr_pkg;

    // Mode register indices
    localparam logic [7:0] ADDR_DEVICE_INFO = 8'h00;
    localparam logic [7:0] ADDR_LATENCY = 8'h02;
    localparam logic [7:0] ADDR_DRIVE = 8'h03;
    localparam logic [7:0] ADDR_TEMP = 8'h04;
    localparam logic [7:0] ADDR_MAKER = 8'h05;
    localparam logic [7:0] ADDR_REV_ONE = 8'h06;
    localparam logic [7:0] ADDR_REV_TWO = 8'h07;
    localparam logic [7:0] ADDR_GEOMETRY = 8'h08;
    localparam logic [7:0] ADDR_TEST = 8'h09;
    localparam logic [7:0] ADDR_CAL = 8'h0a;

    // Latency codes
    localparam logic [3:0] LAT_CODE_MIN = 4'h1;
    localparam logic [3:0] LAT_CODE_MAX = 4'h6;
    localparam logic [3:0] LAT_RESET = 4'h1;

    // Drive strength codes
    localparam logic [3:0] DRV_CODE_MAX = 4'h7;
    localparam logic [3:0] DRV_CODE_HOLE = 4'h5;
    localparam logic [3:0] DRV_RESET = 4'h2;

    // Temperature status layout
    localparam int TUF_POS = 7;
    localparam int HOT_POS = 2;
    localparam logic [2:0] RATE_LOW_LIMIT = 3'h0;
    localparam logic [2:0] RATE_NOMINAL = 3'h3;
    localparam logic [2:0] RATE_RESERVED = 3'h4;
    localparam logic [2:0] RATE_QUARTER_NODERATE = 3'h5;
    localparam logic [2:0] RATE_QUARTER_DERATE = 3'h6;
    localparam logic [2:0] RATE_HIGH_LIMIT = 3'h7;
    localparam logic [2:0] RATE_RESET = 3'h3;

    // Geometry fields
    localparam logic [1:0] GEO_TYPE = 2'h0;
    localparam logic [3:0] GEO_DENSITY = 4'h2;
    localparam logic [1:0] GEO_WIDTH_X32 = 2'h0;
    localparam logic [1:0] GEO_WIDTH_X16 = 2'h1;

    // Device info: bit that reports resistor presence after init calibration
    localparam int INFO_RES_POS = 5;

    // Calibration codes
    localparam logic [7:0] CAL_INIT = 8'hff;
    localparam logic [7:0] CAL_LONG = 8'hab;
    localparam logic [7:0] CAL_SHORT = 8'h56;
    localparam logic [7:0] CAL_RESET = 8'hc3;

    // Vendor test register reset value
    localparam logic [7:0] TEST_RESET = 8'h00;

    // Calibration busy times in cycles of clk_sys
    localparam int CAL_LONG_CYCLES = 36;
    localparam int CAL_SHORT_CYCLES = 9;
    localparam int CAL_INIT_CYCLES = 100;

    // Mode register command from the controller
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] index;
        logic [7:0] data;
    } smr_cmd_t;

    // Calibration request handed to the engine
    typedef enum logic [3:0] {
        CAL_OP_NONE = 4'b0001,
        CAL_OP_INIT = 4'b0010,
        CAL_OP_LONG = 4'b0100,
        CAL_OP_SHORT = 4'b1000
    } smr_cal_op_t;

endpackage

// file: rtl/smr_cal_engine.sv
// Impedance calibration engine: runs a timed calibration and holds its result
`timescale 1ns/1ns
`default_nettype none
module smr_cal_engine
    import smr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Request
    input wire logic start,
    input wire logic [3:0] op,
    input wire logic restore_default,
    // Status
    output logic busy,
    output logic calibrated
);
    typedef enum logic [2:0] {
        CE_IDLE = 3'b001,
        CE_RUN = 3'b010,
        CE_DONE = 3'b100
    } smr_ce_state_t;

    smr_ce_state_t state;
    smr_ce_state_t next_state;
    logic [7:0] count;
    logic [7:0] next_count;

    function automatic logic [7:0] run_len(input logic [3:0] o);
        case (o)
            CAL_OP_INIT: run_len = 8'(CAL_INIT_CYCLES);
            CAL_OP_LONG: run_len = 8'(CAL_LONG_CYCLES);
            default: run_len = 8'(CAL_SHORT_CYCLES);
        endcase
    endfunction

    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            CE_IDLE, CE_DONE: begin
                if (start) begin
                    next_state = CE_RUN;
                    next_count = run_len(op);
                end
            end
            CE_RUN: begin
                next_count = count - 8'h01;
                if (count == 8'h01) begin
                    next_state = CE_DONE;
                end
            end
            default: next_state = CE_IDLE;
        endcase
        if (restore_default) begin
            next_state = CE_IDLE;
            next_count = 8'h00;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= CE_IDLE;
            count <= 8'h00;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    assign busy = (state == CE_RUN);
    assign calibrated = (state == CE_DONE);
endmodule
`default_nettype wire

// file: rtl/smr_mode_register_bank.sv
// Mode register bank for registers 0 and 2 to 10 of a low-power SDRAM
`timescale 1ns/1ns
`default_nettype none
module smr_mode_register_bank
    import smr_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
    parameter logic [7:0] REVISION_ONE = 8'h11, // Arbitrary value
    parameter logic [7:0] REVISION_TWO = 8'h22, // Arbitrary value
    parameter logic X16_PART = 1'b1
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Mode register command
    input wire smr_cmd_t cmd,
    output logic [7:0] read_data,
    output logic read_valid,
    // Temperature sensor (asynchronous)
    input wire logic [2:0] sensor_rate,
    // Calibration pin strap (asynchronous): high when tied to the command bus supply
    input wire logic cal_pin_to_supply,
    // Decoded settings
    output logic [3:0] read_latency_cycles,
    output logic [3:0] write_latency_cycles,
    output logic [3:0] drive_strength_field,
    output logic derate_timing,
    output logic cal_busy,
    output logic cal_default_active
);
    logic [2:0] rate_meta;
    logic [2:0] rate_sync;
    logic [2:0] rate_prev;
    logic strap_meta;
    logic strap_sync;
    logic [3:0] latency_code;
    logic [3:0] drive_code;
    logic [2:0] rate_field;
    logic temperature_update_flag;
    logic res_seen;
    logic [7:0] test_reg;
    logic [7:0] next_read_data;
    logic cal_done;

    // Only legal codes are stored; reserved writes leave the old setting
    function automatic logic lat_ok(input logic [3:0] c);
        lat_ok = (c >= LAT_CODE_MIN) && (c <= LAT_CODE_MAX);
    endfunction

    function automatic logic drv_ok(input logic [3:0] c);
        drv_ok = (c != 4'h0) && (c <= DRV_CODE_MAX) && (c != DRV_CODE_HOLE);
    endfunction

    // Sensor and strap come from outside the clock domain
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rate_meta <= RATE_RESET;
            rate_sync <= RATE_RESET;
            rate_prev <= RATE_RESET;
            strap_meta <= 1'b0;
            strap_sync <= 1'b0;
        end else begin
            rate_meta <= sensor_rate;
            rate_sync <= rate_meta;
            rate_prev <= rate_sync;
            strap_meta <= cal_pin_to_supply;
            strap_sync <= strap_meta;
        end
    end

    wire wr_lat = cmd.wr && (cmd.index == ADDR_LATENCY) && lat_ok(cmd.data[3:0]);
    wire wr_drv = cmd.wr && (cmd.index == ADDR_DRIVE) && drv_ok(cmd.data[3:0]);
    wire wr_test = cmd.wr && (cmd.index == ADDR_TEST);
    wire wr_cal = cmd.wr && (cmd.index == ADDR_CAL);
    wire rd_temp = cmd.rd && (cmd.index == ADDR_TEMP);
    // A code counts only once two synchronised samples agree, so bit skew on a
    // sensor step never flags a false code; reserved 100 keeps the old field
    wire rate_settled = (rate_sync == rate_prev);
    wire rate_new = rate_settled && (rate_sync != RATE_RESERVED) && (rate_sync != rate_field);

    wire code_init = (cmd.data == CAL_INIT);
    wire code_long = (cmd.data == CAL_LONG);
    wire code_short = (cmd.data == CAL_SHORT);
    wire code_reset = (cmd.data == CAL_RESET);
    wire cal_accept = wr_cal && !strap_sync;
    wire cal_start = cal_accept && (code_init || code_long || code_short);
    wire cal_restore = cal_accept && code_reset;
    wire [3:0] cal_op = code_init ? CAL_OP_INIT : (code_long ? CAL_OP_LONG : CAL_OP_SHORT);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            latency_code <= LAT_RESET;
            drive_code <= DRV_RESET;
            test_reg <= TEST_RESET;
        end else begin
            if (wr_lat) begin
                latency_code <= cmd.data[3:0];
            end
            if (wr_drv) begin
                drive_code <= cmd.data[3:0];
            end
            if (wr_test) begin
                test_reg <= cmd.data;
            end
        end
    end

    // Set wins over the read that would clear it, so no change goes unseen
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rate_field <= RATE_RESET;
            temperature_update_flag <= 1'b0;
        end else begin
            if (rate_new) begin
                rate_field <= rate_sync;
            end
            if (rate_new) begin
                temperature_update_flag <= 1'b1;
            end else if (rd_temp) begin
                temperature_update_flag <= 1'b0;
            end
        end
    end

    // Resistor presence is latched only by an accepted init calibration
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            res_seen <= 1'b0;
        end else if (cal_start && code_init) begin
            res_seen <= 1'b1;
        end
    end

    smr_cal_engine u_cal (
        .clk_sys(clk_sys),
        .reset(reset),
        .start(cal_start),
        .op(cal_op),
        .restore_default(cal_restore || strap_sync),
        .busy(cal_busy),
        .calibrated(cal_done)
    );

    wire [7:0] temp_word = {temperature_update_flag, 4'h0, rate_field};
    wire [7:0] geo_word = {X16_PART ? GEO_WIDTH_X16 : GEO_WIDTH_X32, GEO_DENSITY, GEO_TYPE};
    wire [7:0] info_word = 8'(res_seen) << INFO_RES_POS;

    // Write-only and unknown indices read as zero
    always_comb begin
        case (cmd.index)
            ADDR_DEVICE_INFO: next_read_data = info_word;
            ADDR_TEMP: next_read_data = temp_word;
            ADDR_MAKER: next_read_data = MAKER_CODE;
            ADDR_REV_ONE: next_read_data = REVISION_ONE;
            ADDR_REV_TWO: next_read_data = REVISION_TWO;
            ADDR_GEOMETRY: next_read_data = geo_word;
            default: next_read_data = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            read_data <= 8'h00;
            read_valid <= 1'b0;
        end else begin
            read_valid <= cmd.rd;
            if (cmd.rd) begin
                read_data <= next_read_data;
            end
        end
    end

    always_comb begin
        case (latency_code)
            4'h2: {read_latency_cycles, write_latency_cycles} = {4'h4, 4'h2};
            4'h3: {read_latency_cycles, write_latency_cycles} = {4'h5, 4'h2};
            4'h4: {read_latency_cycles, write_latency_cycles} = {4'h6, 4'h3};
            4'h5: {read_latency_cycles, write_latency_cycles} = {4'h7, 4'h4};
            4'h6: {read_latency_cycles, write_latency_cycles} = {4'h8, 4'h4};
            default: {read_latency_cycles, write_latency_cycles} = {4'h3, 4'h1};
        endcase
    end

    assign drive_strength_field = drive_code;
    assign derate_timing = (rate_field == RATE_QUARTER_DERATE);
    assign cal_default_active = !cal_done;

    // Assertions
    property p_tuf_set;
        @(posedge clk_sys) disable iff (reset) rate_new |=> temperature_update_flag;
    endproperty
    a_tuf_set: assert property (p_tuf_set) else $error("flag not set");

    property p_tuf_clear;
        @(posedge clk_sys) disable iff (reset)
            (rd_temp && !rate_new) |=> !temperature_update_flag;
    endproperty
    a_tuf_clear: assert property (p_tuf_clear) else $error("flag not cleared");

    property p_tuf_hold;
        @(posedge clk_sys) disable iff (reset)
            (!rate_new && !rd_temp) |=> $stable(temperature_update_flag);
    endproperty
    a_tuf_hold: assert property (p_tuf_hold) else $error("flag moved");

    property p_tuf_reset;
        @(posedge clk_sys) $fell(reset) |-> !temperature_update_flag;
    endproperty
    a_tuf_reset: assert property (p_tuf_reset) else $error("flag not zero");

    property p_hot_bit;
        @(posedge clk_sys) disable iff (reset)
            rate_field[HOT_POS] |-> (rate_field >= RATE_QUARTER_NODERATE);
    endproperty
    a_hot_bit: assert property (p_hot_bit) else $error("hot bit wrong");

    property p_lat_legal;
        @(posedge clk_sys) disable iff (reset)
            (latency_code >= LAT_CODE_MIN) && (latency_code <= LAT_CODE_MAX);
    endproperty
    a_lat_legal: assert property (p_lat_legal) else $error("latency reserved");

    property p_drv_legal;
        @(posedge clk_sys) disable iff (reset) drv_ok(drive_code);
    endproperty
    a_drv_legal: assert property (p_drv_legal) else $error("drive reserved");

    property p_maker_read;
        @(posedge clk_sys) disable iff (reset)
            (cmd.rd && cmd.index == ADDR_MAKER) |=> (read_valid && read_data == MAKER_CODE);
    endproperty
    a_maker_read: assert property (p_maker_read) else $error("maker code wrong");

    property p_geo_read;
        @(posedge clk_sys) disable iff (reset)
            (cmd.rd && cmd.index == ADDR_GEOMETRY) |=> (read_data[5:2] == GEO_DENSITY);
    endproperty
    a_geo_read: assert property (p_geo_read) else $error("geometry wrong");

    property p_cal_start;
        @(posedge clk_sys) disable iff (reset) cal_start |=> cal_busy;
    endproperty
    a_cal_start: assert property (p_cal_start) else $error("cal not started");

    property p_cal_strap;
        @(posedge clk_sys) disable iff (reset) strap_sync |=> !cal_busy;
    endproperty
    a_cal_strap: assert property (p_cal_strap) else $error("cal ran on strap");

    property p_cal_reserved;
        @(posedge clk_sys) disable iff (reset)
            (wr_cal && !cal_busy && !(code_init || code_long || code_short)) |=> !cal_busy;
    endproperty
    a_cal_reserved: assert property (p_cal_reserved) else $error("reserved ran");

    property p_ro_write;
        @(posedge clk_sys) disable iff (reset)
            (cmd.wr && cmd.index == ADDR_TEMP && !rate_new) |=> $stable(rate_field);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only changed");

    property p_lat_write;
        @(posedge clk_sys) disable iff (reset)
            wr_lat |=> (latency_code == $past(cmd.data[3:0]));
    endproperty
    a_lat_write: assert property (p_lat_write) else $error("latency write lost");

    // Reserved codes must leave the previous setting in place
    property p_lat_keep;
        @(posedge clk_sys) disable iff (reset)
            (cmd.wr && cmd.index == ADDR_LATENCY && !lat_ok(cmd.data[3:0]))
                |=> $stable(latency_code);
    endproperty
    a_lat_keep: assert property (p_lat_keep) else $error("reserved latency stored");

    property p_drv_keep;
        @(posedge clk_sys) disable iff (reset)
            (cmd.wr && cmd.index == ADDR_DRIVE && !drv_ok(cmd.data[3:0]))
                |=> $stable(drive_code);
    endproperty
    a_drv_keep: assert property (p_drv_keep) else $error("reserved drive stored");

    property p_temp_read;
        @(posedge clk_sys) disable iff (reset)
            rd_temp |=> (read_valid && read_data[6:3] == 4'h0);
    endproperty
    a_temp_read: assert property (p_temp_read) else $error("temperature word wrong");

    property p_rev_one_read;
        @(posedge clk_sys) disable iff (reset)
            (cmd.rd && cmd.index == ADDR_REV_ONE) |=> (read_data == REVISION_ONE);
    endproperty
    a_rev_one_read: assert property (p_rev_one_read) else $error("revision one wrong");

    property p_rev_two_read;
        @(posedge clk_sys) disable iff (reset)
            (cmd.rd && cmd.index == ADDR_REV_TWO) |=> (read_data == REVISION_TWO);
    endproperty
    a_rev_two_read: assert property (p_rev_two_read) else $error("revision two wrong");

    property p_wo_read;
        @(posedge clk_sys) disable iff (reset)
            (cmd.rd && (cmd.index == ADDR_LATENCY || cmd.index == ADDR_DRIVE
                || cmd.index == ADDR_TEST || cmd.index == ADDR_CAL))
                |=> (read_data == 8'h00);
    endproperty
    a_wo_read: assert property (p_wo_read) else $error("write-only read nonzero");

    // Reading a write-only register must not touch what it holds
    property p_test_read;
        @(posedge clk_sys) disable iff (reset)
            (cmd.rd && !cmd.wr && cmd.index == ADDR_TEST) |=> $stable(test_reg);
    endproperty
    a_test_read: assert property (p_test_read) else $error("test register moved");

    property p_cal_restore;
        @(posedge clk_sys) disable iff (reset)
            cal_restore |=> (!cal_busy && cal_default_active);
    endproperty
    a_cal_restore: assert property (p_cal_restore) else $error("default not restored");

    property p_strap_write;
        @(posedge clk_sys) disable iff (reset)
            (wr_cal && strap_sync) |=> (!cal_busy && cal_default_active);
    endproperty
    a_strap_write: assert property (p_strap_write) else $error("strap command obeyed");

    c_tuf_cycle: cover property (@(posedge clk_sys) disable iff (reset)
        temperature_update_flag ##1 rd_temp ##1 !temperature_update_flag);
    c_cal_long: cover property (@(posedge clk_sys) disable iff (reset)
        (cal_start && code_long) ##1 cal_busy);
    c_derate: cover property (@(posedge clk_sys) disable iff (reset) derate_timing);
    c_lat_max: cover property (@(posedge clk_sys) disable iff (reset)
        read_latency_cycles == 4'h8);
    c_strap: cover property (@(posedge clk_sys) disable iff (reset)
        wr_cal && strap_sync);
endmodule
`default_nettype wire

// file: sim/smr_ctrl_model.sv
// Memory controller model that issues mode register reads and writes
`timescale 1ns/1ns
`default_nettype none
module smr_ctrl_model
    import smr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Mode register command
    output smr_cmd_t cmd,
    input wire logic [7:0] read_data,
    input wire logic read_valid,
    // Timing feedback
    input wire logic derate_timing
);
    // Extra row timing in ps that the scheduler adds; the clock rate is left alone
    logic [11:0] row_extra_ps;
    assign row_extra_ps = derate_timing ? 12'h753 : 12'h000;

    initial begin
        cmd = '0;
    end

    // Idle lines carry the inverse of the last request so a stale value never passes
    task automatic go_idle();
        cmd.wr = 1'b0;
        cmd.rd = 1'b0;
        cmd.index = ~cmd.index;
        cmd.data = ~cmd.data;
    endtask

    // Reserved calibration codes go out only when a scenario asks for them
    task automatic mr_write(input logic [7:0] index, input logic [7:0] data);
        @(posedge clk_sys);
        #1;
        cmd = {1'b1, 1'b0, index, data};
        @(posedge clk_sys);
        #1;
        go_idle();
    endtask

    // The answer stands for one cycle only, so it is taken right after its edge
    task automatic mr_read(input logic [7:0] index, output logic [7:0] data,
            output logic valid);
        @(posedge clk_sys);
        #1;
        cmd = {1'b0, 1'b1, index, 8'h00};
        @(posedge clk_sys);
        #1;
        go_idle();
        data = read_data;
        valid = read_valid;
    endtask
endmodule
`default_nettype wire

// file: sim/sdram_mode_register_bank_tb.sv
// Self-checking testbench for the mode register bank
`timescale 1ns/1ns
`default_nettype none
module sdram_mode_register_bank_tb
    import smr_pkg::*;
;
    logic clk_sys;
    logic reset;
    smr_cmd_t cmd;
    logic [7:0] read_data;
    logic read_valid;
    logic [2:0] sensor_rate;
    logic cal_pin_to_supply;
    logic [3:0] read_latency_cycles;
    logic [3:0] write_latency_cycles;
    logic [3:0] drive_strength_field;
    logic derate_timing;
    logic cal_busy;
    logic cal_default_active;
    int seed = 10;
    int fails = 0;
    int n_checks = 0;
    logic [31:0] r;
    logic [7:0] d;
    logic [7:0] lat;
    logic [3:0] drv;
    logic [2:0] exp_rate;
    logic exp_flag;
    logic [2:0] rates [8] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7, 3'h0, 3'h4, 3'h3};
    logic [7:0] ro_exp [4] = '{8'h5a, 8'h11, 8'h22, 8'h48};
    logic [7:0] wo_idx [5] = '{ADDR_LATENCY, ADDR_DRIVE, ADDR_TEST, ADDR_CAL, 8'h01};

    smr_mode_register_bank #(.MAKER_CODE(8'h5a), .REVISION_ONE(8'h11),
            .REVISION_TWO(8'h22), .X16_PART(1'b1)) u_dut (
        .clk_sys(clk_sys), .reset(reset), .cmd(cmd), .read_data(read_data),
        .read_valid(read_valid), .sensor_rate(sensor_rate),
        .cal_pin_to_supply(cal_pin_to_supply), .read_latency_cycles(read_latency_cycles),
        .write_latency_cycles(write_latency_cycles),
        .drive_strength_field(drive_strength_field), .derate_timing(derate_timing),
        .cal_busy(cal_busy), .cal_default_active(cal_default_active));

    smr_ctrl_model u_ctrl (
        .clk_sys(clk_sys), .reset(reset), .cmd(cmd), .read_data(read_data),
        .read_valid(read_valid), .derate_timing(derate_timing));

    initial begin
        clk_sys = 1'b0;
    end
    always #5 clk_sys = ~clk_sys;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (fails == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    function automatic logic [7:0] lat_pair(input logic [3:0] code);
        logic [3:0] wl;
        case (code)
            4'h1: wl = 4'h1;
            4'h2, 4'h3: wl = 4'h2;
            4'h4: wl = 4'h3;
            default: wl = 4'h4;
        endcase
        return {code + 4'h2, wl};
    endfunction

    task automatic rd(input logic [7:0] idx, output logic [7:0] dv);
        logic v;
        u_ctrl.mr_read(idx, dv, v);
        check({7'h00, v}, 8'h01);
    endtask

    // Two synchroniser flops and a settle stage: the field lags by four edges
    task automatic set_sensor(input logic [2:0] c);
        @(posedge clk_sys);
        #1;
        sensor_rate = c;
        if (c != RATE_RESERVED && c != exp_rate) begin
            exp_flag = 1'b1;
            exp_rate = c;
        end
        repeat (4) @(posedge clk_sys);
        #1;
    endtask

    task automatic cal_run(input logic [7:0] code, input int exp_n, input logic exp_def);
        int n;
        n = 0;
        u_ctrl.mr_write(ADDR_CAL, code);
        while (cal_busy === 1'b1 && n < 300) begin
            n++;
            @(posedge clk_sys);
            #1;
        end
        check(8'(n), 8'(exp_n));
        check({7'h00, cal_default_active}, {7'h00, exp_def});
    endtask

    initial begin
        #100000;
        fails++;
        report_and_stop();
    end

    initial begin
        reset = 1'b1;
        sensor_rate = RATE_RESET;
        cal_pin_to_supply = 1'b0;
        exp_rate = RATE_RESET;
        exp_flag = 1'b0;
        lat = 8'h31;
        drv = DRV_RESET;
        repeat (2) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        check({read_latency_cycles, write_latency_cycles}, lat);
        check({4'h0, drive_strength_field}, {4'h0, drv});
        // Writes to read-only places must not disturb what they return
        for (int i = 0; i < 5; i++) begin
            r = $random(seed);
            u_ctrl.mr_write(ADDR_TEMP + 8'(i), r[7:0]);
        end
        rd(ADDR_TEMP, d);
        check(d, 8'h03);
        for (int i = 0; i < 4; i++) begin
            rd(ADDR_MAKER + 8'(i), d);
            check(d, ro_exp[i]);
        end
        r = $random(seed);
        u_ctrl.mr_write(8'h0b + {1'b0, r[6:0]}, r[15:8]);
        rd(8'h0b + {1'b0, r[6:0]}, d);
        check(d, 8'h00);
        rd(ADDR_DEVICE_INFO, d);
        check({7'h00, d[INFO_RES_POS]}, 8'h00);
        for (int c = 0; c < 16; c++) begin
            r = $random(seed);
            u_ctrl.mr_write(ADDR_LATENCY, {r[3:0], 4'(c)});
            if (c >= 1 && c <= 6) lat = lat_pair(4'(c));
            check({read_latency_cycles, write_latency_cycles}, lat);
            u_ctrl.mr_write(ADDR_DRIVE, {r[7:4], 4'(c)});
            if (c >= 1 && c <= 7 && c != 5) drv = 4'(c);
            check({4'h0, drive_strength_field}, {4'h0, drv});
        end
        foreach (wo_idx[i]) begin
            rd(wo_idx[i], d);
            check(d, 8'h00);
        end
        foreach (rates[i]) begin
            set_sensor(rates[i]);
            rd(ADDR_TEMP, d);
            check(d, {exp_flag, 4'h0, exp_rate});
            exp_flag = 1'b0;
            check({7'h00, derate_timing}, {7'h00, exp_rate == RATE_QUARTER_DERATE});
            rd(ADDR_TEMP, d);
            check(d, {4'h0, 1'b0, exp_rate});
        end
        // A change that returns to the old code before the read still flags
        set_sensor(3'h6);
        set_sensor(3'h3);
        rd(ADDR_TEMP, d);
        check(d, 8'h83);
        do begin
            r = $random(seed);
        end while (r[7:0] inside {CAL_INIT, CAL_LONG, CAL_SHORT, CAL_RESET});
        cal_run(r[7:0], 0, 1'b1);
        cal_run(CAL_LONG, CAL_LONG_CYCLES, 1'b0);
        cal_run(CAL_RESET, 0, 1'b1);
        cal_run(CAL_SHORT, CAL_SHORT_CYCLES, 1'b0);
        cal_run(CAL_INIT, CAL_INIT_CYCLES, 1'b0);
        rd(ADDR_DEVICE_INFO, d);
        check({7'h00, d[INFO_RES_POS]}, 8'h01);
        @(posedge clk_sys);
        #1;
        cal_pin_to_supply = 1'b1;
        repeat (3) @(posedge clk_sys);
        cal_run(CAL_LONG, 0, 1'b1);
        // Second reset in mid-run brings the defaults and a clear flag back
        set_sensor(3'h5);
        @(posedge clk_sys);
        #1;
        reset = 1'b1;
        sensor_rate = RATE_RESET;
        repeat (2) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        check({read_latency_cycles, write_latency_cycles}, 8'h31);
        check({4'h0, drive_strength_field}, {4'h0, DRV_RESET});
        rd(ADDR_TEMP, d);
        check(d, 8'h03);
        report_and_stop();
    end
endmodule
`default_nettype wire
